// ==== src/sic_top.v ====
// Serial initiator controller with APB registers and two FIFOs
`timescale 1ns/1ps
`include "sic_defines.vh"

// Summary of operation
// - Serial clock rests at the level chosen by clock polarity outside frames.
// - Phase zero: select falls first, capture on first edge, shift on second.
// - Phase one: drive on leading edges, capture on trailing edges.
// - Mode zero pops each frame and pushes every received word.
// - In modes zero and one, target select is released once the transmit FIFO is empty.
// - Transmit-only mode never pushes received words.
// - Receive-only mode holds data out constant and pushes each frame.
// - EEPROM mode sends FIFO frames, ignoring data in meanwhile.
// - EEPROM mode then receives read frame count plus one frames.
// - Generated serial clock never exceeds half the core clock.
// - Serial clock toggles only during an active transfer, or moves to a new rest level when a control write changes clock polarity.
// - Serial clock is core clock over divider; zero divider disables it.
// - With the controller disabled nothing transfers and the clock idles.
// - Both FIFOs hold 64 sixteen-bit frames; unused upper bits ignored.
// - Data port write pushes transmit FIFO; read pops receive FIFO.
// - Transmit empty request when level is at or below threshold.
// - Receive full request when level reaches threshold plus one.
// - Writing data port with a full transmit FIFO flags overflow.
// - Frame arriving at a full receive FIFO flags overrun, word lost.
// - Reading data port with an empty receive FIFO flags underflow.
// - Frame length is programmable from two to sixteen bits.
module sic_top (
	input wire clock,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg serial_clock_out,
	output reg target_select_n,
	output reg serial_data_out,
	input wire serial_data_in,
	output reg irq_tx_empty,
	output reg irq_tx_overflow,
	output reg irq_rx_full,
	output reg irq_rx_overrun,
	output reg irq_rx_underflow
);

localparam ST_IDLE = 1'b0;
localparam ST_FRAME = 1'b1;

// ----------------------------------------
// Registers
// ----------------------------------------
reg [`SIC_C0_W-1:0] control_zero;
reg [15:0] read_frame_count;
reg controller_enable;
reg [15:0] clock_divider;
reg [7:0] tx_threshold_code;
reg [7:0] rx_threshold_code;
reg [`SIC_M_W-1:0] irq_mask;
reg tx_overflow_flag;
reg rx_underflow_flag;
reg rx_overrun_flag;

// ----------------------------------------
// Engine state
// ----------------------------------------
reg state;
reg rx_phase;
reg [15:0] rx_left;
reg [`SIC_ECW-1:0] edge_cnt;
reg [`SIC_DW-1:0] tx_shift;
reg [`SIC_DW-1:0] rx_shift;

wire clock_phase = control_zero[`SIC_C0_CPHA];
wire clock_polarity = control_zero[`SIC_C0_CPOL];
wire [1:0] transfer_mode = control_zero[`SIC_C0_TRANSFER_MODE];
wire [1:0] frame_format_select = control_zero[`SIC_C0_FRF];
wire [4:0] frame_len = {1'b0, control_zero[`SIC_C0_DFS]} + 5'h01;
wire [`SIC_ECW-1:0] last_edge = {frame_len, 1'b0};

wire tick;
wire [`SIC_DW-1:0] tx_pop_data;
wire [`SIC_DW-1:0] rx_pop_data;
wire [`SIC_LW-1:0] tx_level;
wire [`SIC_LW-1:0] rx_level;
wire tx_full;
wire tx_empty;
wire rx_full;
wire rx_empty;

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire access = psel && penable;
wire wr_en = access && pready && pwrite;
wire rd_first = access && !pready && !pwrite;
wire addr_hit = (paddr == `SIC_OFS_CTRL0) || (paddr == `SIC_OFS_CTRL1) ||
	(paddr == `SIC_OFS_ENABLE) || (paddr == `SIC_OFS_BAUD) ||
	(paddr == `SIC_OFS_TXTHR) || (paddr == `SIC_OFS_RXTHR) ||
	(paddr == `SIC_OFS_MASK) || (paddr == `SIC_OFS_STATUS) ||
	(paddr == `SIC_OFS_TXLVL) || (paddr == `SIC_OFS_RXLVL) ||
	(paddr == `SIC_OFS_DATA);
wire data_wr = wr_en && paddr == `SIC_OFS_DATA;
wire data_rd = rd_first && paddr == `SIC_OFS_DATA;
wire tx_push = data_wr && !tx_full;
wire rx_pop = data_rd && !rx_empty;

// ----------------------------------------
// Frame sequencing
// ----------------------------------------
wire run_ok = controller_enable && clock_divider[15:1] != 15'h0000 &&
	frame_format_select == 2'h0;
wire start = state == ST_IDLE && run_ok && !tx_empty;
wire at_tick = state == ST_FRAME && tick;
wire at_end = at_tick && edge_cnt == last_edge;
wire tx_pop = start || (at_end && !rx_phase && !tx_empty);
wire to_rx = at_end && !rx_phase && tx_empty && transfer_mode == `SIC_MODE_EEP;
wire rx_more = at_end && rx_phase && rx_left != 16'h0000;
wire load = tx_pop || to_rx || rx_more;
wire load_zero = (start && transfer_mode == `SIC_MODE_RXO) || to_rx || rx_more;
wire leading = edge_cnt[0];
wire sample = at_tick && edge_cnt != 6'h00 && (clock_phase ? !leading : leading);
wire drive = at_tick && edge_cnt != 6'h00 &&
	(clock_phase ? leading : (!leading && edge_cnt != last_edge));
wire [`SIC_DW-1:0] next_rx = {rx_shift[`SIC_DW-2:0], serial_data_in};
wire [`SIC_DW-1:0] len_mask = 16'hFFFF >> (5'h10 - frame_len);
wire [`SIC_DW-1:0] rx_word = (clock_phase ? next_rx : rx_shift) & len_mask;
wire [`SIC_DW-1:0] next_aligned = load_zero ? 16'h0000 : (tx_pop_data << (5'h10 - frame_len));
wire rx_push = at_end && (transfer_mode == `SIC_MODE_TXRX || rx_phase);
wire tx_empty_status = {1'b0, tx_level} <= tx_threshold_code;
wire rx_full_status = {2'b00, rx_level} >= {1'b0, rx_threshold_code} + 9'h001;

sic_fifo u_tx_fifo (
	.clock(clock),
	.srst(srst),
	.push(tx_push),
	.push_data(pwdata[`SIC_DW-1:0]),
	.pop(tx_pop),
	.pop_data(tx_pop_data),
	.level(tx_level),
	.full(tx_full),
	.empty(tx_empty)
);

sic_fifo u_rx_fifo (
	.clock(clock),
	.srst(srst),
	.push(rx_push),
	.push_data(rx_word),
	.pop(rx_pop),
	.pop_data(rx_pop_data),
	.level(rx_level),
	.full(rx_full),
	.empty(rx_empty)
);

sic_clkgen u_clkgen (
	.clock(clock),
	.srst(srst),
	.run(state == ST_FRAME),
	.half(clock_divider[15:1]),
	.tick(tick)
);

// ----------------------------------------
// Serial engine
// ----------------------------------------
always @(posedge clock) begin
	if (srst) begin
		state <= ST_IDLE;
		rx_phase <= 1'b0;
		rx_left <= 16'h0000;
		edge_cnt <= 6'h00;
		tx_shift <= 16'h0000;
		rx_shift <= 16'h0000;
		serial_clock_out <= 1'b0;
		target_select_n <= 1'b1;
		serial_data_out <= 1'b0;
	end else if (!run_ok) begin
		state <= ST_IDLE;
		rx_phase <= 1'b0;
		edge_cnt <= 6'h00;
		serial_clock_out <= clock_polarity;
		target_select_n <= 1'b1;
	end else if (state == ST_IDLE) begin
		serial_clock_out <= clock_polarity;
		target_select_n <= 1'b1;
		if (start) begin
			state <= ST_FRAME;
			target_select_n <= 1'b0;
			rx_phase <= transfer_mode == `SIC_MODE_RXO;
			rx_left <= read_frame_count;
		end
	end else if (at_tick) begin
		edge_cnt <= edge_cnt + 6'h01;
		if (edge_cnt != 6'h00) begin
			serial_clock_out <= ~serial_clock_out;
		end
		if (sample) begin
			rx_shift <= next_rx;
		end
		if (drive) begin
			serial_data_out <= tx_shift[`SIC_DW-1];
			tx_shift <= tx_shift << 1;
		end
		if (at_end) begin
			edge_cnt <= 6'h00;
			if (to_rx) begin
				rx_phase <= 1'b1;
			end
			if (rx_more) begin
				rx_left <= rx_left - 16'h0001;
			end
			if (!load) begin
				state <= ST_IDLE;
				target_select_n <= 1'b1;
			end
		end
	end
	if (!srst && run_ok && load) begin
		if (clock_phase) begin
			tx_shift <= next_aligned;
		end else begin
			serial_data_out <= next_aligned[`SIC_DW-1];
			tx_shift <= next_aligned << 1;
		end
	end
end

// ----------------------------------------
// Register writes and sticky flags
// ----------------------------------------
always @(posedge clock) begin
	if (srst) begin
		control_zero <= `SIC_C0_RESET;
		read_frame_count <= 16'h0000;
		controller_enable <= 1'b0;
		clock_divider <= 16'h0000;
		tx_threshold_code <= 8'h00;
		rx_threshold_code <= 8'h00;
		irq_mask <= 5'h00;
		tx_overflow_flag <= 1'b0;
		rx_underflow_flag <= 1'b0;
		rx_overrun_flag <= 1'b0;
	end else begin
		if (wr_en) begin
			case (paddr)
				`SIC_OFS_CTRL0: begin
					control_zero <= pwdata[`SIC_C0_W-1:0];
					if (pwdata[`SIC_C0_DFS] < `SIC_DFS_MIN) begin
						control_zero[`SIC_C0_DFS] <= `SIC_DFS_MIN;
					end
				end
				`SIC_OFS_CTRL1: read_frame_count <= pwdata[15:0];
				`SIC_OFS_ENABLE: controller_enable <= pwdata[0];
				`SIC_OFS_BAUD: clock_divider <= {pwdata[15:1], 1'b0};
				`SIC_OFS_TXTHR: tx_threshold_code <= pwdata[7:0];
				`SIC_OFS_RXTHR: rx_threshold_code <= pwdata[7:0];
				`SIC_OFS_MASK: irq_mask <= pwdata[`SIC_M_W-1:0];
				default: begin
				end
			endcase
		end
		tx_overflow_flag <= (tx_overflow_flag &
			!(wr_en && paddr == `SIC_OFS_STATUS && pwdata[`SIC_S_TXO])) |
			(data_wr && tx_full);
		rx_underflow_flag <= (rx_underflow_flag &
			!(wr_en && paddr == `SIC_OFS_STATUS && pwdata[`SIC_S_RXU])) |
			(data_rd && rx_empty);
		rx_overrun_flag <= (rx_overrun_flag &
			!(wr_en && paddr == `SIC_OFS_STATUS && pwdata[`SIC_S_RXO])) |
			(rx_push && rx_full);
	end
end

// ----------------------------------------
// Request outputs
// ----------------------------------------
always @(posedge clock) begin
	if (srst) begin
		irq_tx_empty <= 1'b0;
		irq_tx_overflow <= 1'b0;
		irq_rx_full <= 1'b0;
		irq_rx_overrun <= 1'b0;
		irq_rx_underflow <= 1'b0;
	end else begin
		irq_tx_empty <= tx_empty_status && irq_mask[`SIC_M_TXE];
		irq_tx_overflow <= tx_overflow_flag && irq_mask[`SIC_M_TXO];
		irq_rx_full <= rx_full_status && irq_mask[`SIC_M_RXF];
		irq_rx_overrun <= rx_overrun_flag && irq_mask[`SIC_M_RXO];
		irq_rx_underflow <= rx_underflow_flag && irq_mask[`SIC_M_RXU];
	end
end

// ----------------------------------------
// Bus answer
// ----------------------------------------
reg [31:0] rd_mux;

always @* begin
	rd_mux = 32'h0000_0000;
	case (paddr)
		`SIC_OFS_CTRL0: rd_mux[`SIC_C0_W-1:0] = control_zero;
		`SIC_OFS_CTRL1: rd_mux[15:0] = read_frame_count;
		`SIC_OFS_ENABLE: rd_mux[0] = controller_enable;
		`SIC_OFS_BAUD: rd_mux[15:0] = clock_divider;
		`SIC_OFS_TXTHR: rd_mux[7:0] = tx_threshold_code;
		`SIC_OFS_RXTHR: rd_mux[7:0] = rx_threshold_code;
		`SIC_OFS_MASK: rd_mux[`SIC_M_W-1:0] = irq_mask;
		`SIC_OFS_STATUS: begin
			rd_mux[`SIC_S_BUSY] = state;
			rd_mux[`SIC_S_TXE] = tx_empty_status;
			rd_mux[`SIC_S_RXF] = rx_full_status;
			rd_mux[`SIC_S_TXO] = tx_overflow_flag;
			rd_mux[`SIC_S_RXU] = rx_underflow_flag;
			rd_mux[`SIC_S_RXO] = rx_overrun_flag;
		end
		`SIC_OFS_TXLVL: rd_mux[`SIC_LW-1:0] = tx_level;
		`SIC_OFS_RXLVL: rd_mux[`SIC_LW-1:0] = rx_level;
		`SIC_OFS_DATA: rd_mux[`SIC_DW-1:0] = rx_empty ? 16'h0000 : rx_pop_data;
		default: rd_mux = 32'h0000_0000;
	endcase
end

always @(posedge clock) begin
	if (srst) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end else begin
		pready <= access && !pready;
		if (access && !pready) begin
			pslverr <= !addr_hit;
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end
end

endmodule // sic_top

// ==== src/sic_defines.vh ====
// Constants shared by the serial initiator controller files
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH

// ----------------------------------------
// Data path sizes
// ----------------------------------------
`define SIC_DW 16
`define SIC_AW 6
`define SIC_LW 7
`define SIC_DEPTH 7'h40
`define SIC_ECW 6

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SIC_OFS_CTRL0 8'h00
`define SIC_OFS_CTRL1 8'h04
`define SIC_OFS_ENABLE 8'h08
`define SIC_OFS_BAUD 8'h0C
`define SIC_OFS_TXTHR 8'h10
`define SIC_OFS_RXTHR 8'h14
`define SIC_OFS_MASK 8'h18
`define SIC_OFS_STATUS 8'h1C
`define SIC_OFS_TXLVL 8'h20
`define SIC_OFS_RXLVL 8'h24
`define SIC_OFS_DATA 8'h60

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define SIC_C0_DFS 3:0
`define SIC_C0_FRF 5:4
`define SIC_C0_CPHA 6
`define SIC_C0_CPOL 7
`define SIC_C0_TRANSFER_MODE 9:8
`define SIC_C0_W 10
`define SIC_M_TXE 0
`define SIC_M_TXO 1
`define SIC_M_RXU 2
`define SIC_M_RXO 3
`define SIC_M_RXF 4
`define SIC_M_W 5
`define SIC_S_BUSY 0
`define SIC_S_TXE 1
`define SIC_S_RXF 2
`define SIC_S_TXO 3
`define SIC_S_RXU 4
`define SIC_S_RXO 5

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define SIC_C0_RESET 10'h007
`define SIC_DFS_MIN 4'h1
`define SIC_MODE_TXRX 2'h0
`define SIC_MODE_TXO 2'h1
`define SIC_MODE_RXO 2'h2
`define SIC_MODE_EEP 2'h3

`endif

// ==== src/sic_fifo.v ====
// Sixty-four entry sixteen bit flip-flop FIFO
`timescale 1ns/1ps
`include "sic_defines.vh"

module sic_fifo (
	input wire clock,
	input wire srst,
	input wire push,
	input wire [`SIC_DW-1:0] push_data,
	input wire pop,
	output wire [`SIC_DW-1:0] pop_data,
	output reg [`SIC_LW-1:0] level,
	output wire full,
	output wire empty
);

reg [`SIC_DW-1:0] mem [0:`SIC_DEPTH-1];
reg [`SIC_AW-1:0] wr_idx;
reg [`SIC_AW-1:0] rd_idx;
wire do_push;
wire do_pop;

assign full = (level == `SIC_DEPTH);
assign empty = (level == 7'h00);
assign do_push = push && !full;
assign do_pop = pop && !empty;
assign pop_data = mem[rd_idx];

// ----------------------------------------
// Storage and pointers
// ----------------------------------------
always @(posedge clock) begin
	if (do_push) begin
		mem[wr_idx] <= push_data;
	end
end

always @(posedge clock) begin
	if (srst) begin
		wr_idx <= 6'h00;
		rd_idx <= 6'h00;
		level <= 7'h00;
	end else begin
		if (do_push) begin
			wr_idx <= wr_idx + 6'h01;
		end
		if (do_pop) begin
			rd_idx <= rd_idx + 6'h01;
		end
		if (do_push && !do_pop) begin
			level <= level + 7'h01;
		end else if (do_pop && !do_push) begin
			level <= level - 7'h01;
		end
	end
end

endmodule // sic_fifo

// ==== src/sic_clkgen.v ====
// Half period tick generator for the serial clock
`timescale 1ns/1ps
`include "sic_defines.vh"

module sic_clkgen (
	input wire clock,
	input wire srst,
	input wire run,
	input wire [14:0] half,
	output reg tick
);

reg [14:0] cnt;

// ----------------------------------------
// Divider
// ----------------------------------------
always @(posedge clock) begin
	if (srst || !run || half == 15'h0000) begin
		cnt <= 15'h0000;
		tick <= 1'b0;
	end else if (cnt == half - 15'h0001) begin
		cnt <= 15'h0000;
		tick <= 1'b1;
	end else begin
		cnt <= cnt + 15'h0001;
		tick <= 1'b0;
	end
end

endmodule // sic_clkgen

// ==== sim/sic_monitor.sv ====
// Port checker for the serial initiator controller
`timescale 1ns/1ps
module sic_monitor (
	input wire clock,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire serial_clock_out,
	input wire target_select_n,
	input wire irq_tx_overflow,
	input wire irq_rx_overrun,
	input wire irq_rx_underflow
);
	// ----
	// Assertions
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire en_wr = pready && pwrite && (paddr == 8'h08 || paddr == 8'h00);
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	access_answer_a: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("access not answered");
	addr_decode_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C,
		8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h60}))
		else $error("wrong error response");
	read_hold_a: assert property (!psel |-> $stable(prdata) && $stable(pslverr))
		else $error("read data moved while idle");
	reset_idle_a: assert property ($past(srst) |-> target_select_n && !serial_clock_out && !pready
		&& !irq_tx_overflow && !irq_rx_overrun && !irq_rx_underflow)
		else $error("outputs not idle after reset");
	clock_idle_a: assert property ($changed(serial_clock_out) |-> !$past(target_select_n)
		|| $past(en_wr) || $past(en_wr, 2))
		else $error("serial clock moved outside frame");
	setup_half_a: assert property ($fell(target_select_n) |-> $stable(serial_clock_out)
		##1 $stable(serial_clock_out))
		else $error("clock edge too soon after select");
	frame_clock_a: assert property ($fell(target_select_n) |-> ##[2:300] $changed(serial_clock_out))
		else $error("no clock edge in frame");
	cover property ($fell(target_select_n));
	cover property ($rose(irq_tx_overflow));
	cover property ($rose(irq_rx_overrun));
endmodule // sic_monitor

bind sic_top sic_monitor mon (
	.clock(clock),
	.srst(srst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.serial_clock_out(serial_clock_out),
	.target_select_n(target_select_n),
	.irq_tx_overflow(irq_tx_overflow),
	.irq_rx_overrun(irq_rx_overrun),
	.irq_rx_underflow(irq_rx_underflow)
);

// ==== sim/sic_target.sv ====
// Serial target peripheral model
`timescale 1ns/1ps
module sic_target (
	input logic serial_clock_out,
	input logic target_select_n,
	input logic serial_data_out,
	input logic clock_phase,
	input logic clock_polarity,
	input logic [15:0] reply,
	input logic [4:0] len,
	output logic serial_data_in,
	output logic [15:0] got
);
	logic [15:0] shreg;
	logic active = 1'b0;
	int edges;
	initial serial_data_in = 1'b0;
	task automatic drive();
		serial_data_in = shreg[15];
		shreg = shreg << 1;
	endtask
	task automatic load();
		shreg = reply << (16 - len);
		edges = 0;
		if (!clock_phase) begin
			drive();
		end
	endtask
	always @(negedge target_select_n) begin
		active = 1'b1;
		load();
	end
	// Released line shows the inverse of its last bit
	always @(posedge target_select_n) begin
		#1;
		active = 1'b0;
		serial_data_in = ~serial_data_in;
	end
	always @(serial_clock_out) begin
		if (active) begin
			edges++;
			if ((serial_clock_out != clock_polarity) != clock_phase) begin
				got = {got[14:0], serial_data_out};
			end else begin
				drive();
			end
			if (edges == 2 * len) begin
				load();
			end
		end
	end
endmodule // sic_target

// ==== sim/sic_top_tb.sv ====
// Self-checking bench for the serial initiator controller
`timescale 1ns/1ps
`include "sic_defines.vh"
module sic_top_tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, m;
	logic pready, pslverr, rd_err, sclk, tsn, sdo, sdi;
	logic [4:0] irq;
	logic cpha = 1'b0;
	logic cpol = 1'b0;
	logic [4:0] len = 5'h8;
	logic [4:0] lens [4] = '{5'h2, 5'h8, 5'h10, 5'h5};
	logic [15:0] got;
	int fail_count = 0;
	int samples_checked = 0;
	int gap = 0;
	int gap_run = 0;
	logic sclk_q = 1'b0;
	always #50 clock = ~clock;
	// Core cycles between serial clock edges
	always @(posedge clock) begin
		sclk_q <= sclk;
		gap_run <= (sclk !== sclk_q) ? 1 : gap_run + 1;
		if (sclk !== sclk_q) begin
			gap <= gap_run;
		end
	end
	sic_top dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clock_out(sclk), .target_select_n(tsn), .serial_data_out(sdo), .serial_data_in(sdi),
		.irq_tx_empty(irq[0]), .irq_tx_overflow(irq[1]), .irq_rx_full(irq[2]), .irq_rx_overrun(irq[3]),
		.irq_rx_underflow(irq[4]));
	sic_target peer (.serial_clock_out(sclk), .target_select_n(tsn), .serial_data_out(sdo),
		.clock_phase(cpha), .clock_polarity(cpol), .reply(16'hA5C3), .len(len), .serial_data_in(sdi),
		.got(got));
	// ----
	// Tasks
	// ----
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic chk_irq(input string name, input logic [4:0] exp);
		repeat (2) @(negedge clock);
		check(name, {27'h0, exp}, {27'h0, irq});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, `SIC_OFS_STATUS, 32'h0);
			n++;
		end while (rd[`SIC_S_BUSY] !== 1'b0 && n < 3000);
		if (n >= 3000) fail_count++;
	endtask
	function automatic logic [31:0] ctrl(input logic [1:0] md, input logic [1:0] pp, input logic [4:0] l);
		return {22'h0, md, pp, 2'h0, 4'(l - 5'h1)};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#(100 * 60000);
		fail_count++;
		report_and_stop();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rdchk(`SIC_OFS_CTRL0, 32'h7, "control");
		rdchk(`SIC_OFS_STATUS, 32'h2, "status");
		rdchk(8'h40, 32'h0, "unmapped");
		check("unmapped error", 32'h1, {31'h0, rd_err});
		apb(1'b1, `SIC_OFS_MASK, 32'h1F);
		apb(1'b0, `SIC_OFS_DATA, 32'h0);
		rdchk(`SIC_OFS_STATUS, 32'h12, "status underflow");
		chk_irq("irq underflow", 5'h11);
		apb(1'b1, `SIC_OFS_STATUS, 32'h38);
		chk_irq("irq cleared", 5'h01);
		$display("register test done");
		apb(1'b1, `SIC_OFS_BAUD, 32'h4);
		for (int i = 0; i < 4; i++) begin
			cpha <= i[0];
			cpol <= i[1];
			len <= lens[i];
			m = (32'h1 << lens[i]) - 32'h1;
			apb(1'b1, `SIC_OFS_ENABLE, 32'h0);
			apb(1'b1, `SIC_OFS_CTRL0, ctrl(2'h0, i[1:0], lens[i]));
			apb(1'b1, `SIC_OFS_ENABLE, 32'h1);
			check("idle clock", {31'h0, cpol}, {31'h0, sclk});
			apb(1'b1, `SIC_OFS_DATA, 32'h1234);
			apb(1'b1, `SIC_OFS_DATA, 32'h9C3A);
			wait_idle();
			check("half period", 32'h2, 32'(gap));
			check("sent bits", 32'h9C3A & m, {16'h0, got} & m);
			check("select released", 32'h1, {31'h0, tsn});
			check("clock rest", {31'h0, cpol}, {31'h0, sclk});
			rdchk(`SIC_OFS_DATA, 32'hA5C3 & m, "rx word 0");
			rdchk(`SIC_OFS_DATA, 32'hA5C3 & m, "rx word 1");
		end
		$display("transfer test done");
		cpha <= 1'b0;
		cpol <= 1'b0;
		len <= 5'h8;
		for (int md = 1; md < 4; md++) begin
			apb(1'b1, `SIC_OFS_ENABLE, 32'h0);
			apb(1'b1, `SIC_OFS_CTRL1, 32'h1);
			apb(1'b1, `SIC_OFS_CTRL0, ctrl(md[1:0], 2'h0, 5'h8));
			apb(1'b1, `SIC_OFS_ENABLE, 32'h1);
			apb(1'b1, `SIC_OFS_DATA, 32'h0A);
			wait_idle();
			rdchk(`SIC_OFS_RXLVL, md == 1 ? 32'h0 : 32'h2, "rx level");
			for (int k = 0; k < (md == 1 ? 0 : 2); k++) begin
				rdchk(`SIC_OFS_DATA, 32'hC3, "read frame");
			end
		end
		$display("mode test done");
		len <= 5'h2;
		apb(1'b1, `SIC_OFS_ENABLE, 32'h0);
		apb(1'b1, `SIC_OFS_CTRL0, ctrl(2'h0, 2'h0, 5'h2));
		apb(1'b1, `SIC_OFS_BAUD, 32'h2);
		for (int k = 0; k < 65; k++) begin
			apb(1'b1, `SIC_OFS_DATA, 32'(k));
		end
		rdchk(`SIC_OFS_TXLVL, 32'h40, "tx level");
		chk_irq("irq overflow", 5'h02);
		apb(1'b1, `SIC_OFS_TXTHR, 32'h40);
		apb(1'b1, `SIC_OFS_RXTHR, 32'h3F);
		chk_irq("irq threshold", 5'h03);
		apb(1'b1, `SIC_OFS_STATUS, 32'h38);
		apb(1'b1, `SIC_OFS_ENABLE, 32'h1);
		wait_idle();
		check("half period fast", 32'h1, 32'(gap));
		rdchk(`SIC_OFS_RXLVL, 32'h40, "rx level full");
		chk_irq("irq rx full", 5'h05);
		apb(1'b1, `SIC_OFS_DATA, 32'h1);
		wait_idle();
		chk_irq("irq overrun", 5'h0D);
		rdchk(`SIC_OFS_RXLVL, 32'h40, "rx level kept");
		$display("fifo test done");
		report_and_stop();
	end
endmodule // sic_top_tb
